// ---- led_driver_config_packet_pwm.sv ----
// Notes on behaviour
// - Idle prefix over 172 clocks starts packet.
// - Wide header bits 11:10 are ignored.
// - Second chain length copy must match first.
// - Wide payload: spare, word one, repeat, word two.
// - Differing word one copies leave registers unchanged.
// - Farthest payload first, own payload last.
// - Narrow format: 30-bit header, 30-bit payload.
// - Narrow command code 110111 selects narrow format.
// - Four header parity bits; mismatch drops packet.
// - Narrow header low bits carry chain length.
// - Narrow payload: word one twice, spare, word two.
// - Wide mode scrambles cycle into 64 segments.
// - Narrow mode uses plain 1024-level modulation.
// - Default count clock is oscillator over two.
// - Wide on-time equals value over 65536.
// - Wide command 100011 sent twice, must match.
// - Word one bits 9:8 pick divider 1/2/4/8.
// - Auto sync loads new data at cycle end.
// - Counter restarts after configuration write when enabled.
`default_nettype none
module led_driver_config_packet_pwm #(
   parameter int unsigned IDLE_CYCLES = led_cfg_pkg::IDLE_CYC,
   parameter int unsigned LINK_HALF   = led_cfg_pkg::LINK_HALF_CYC
) (
   input  wire logic                                 sys_clk_i,
   input  wire logic                                 rst_i,
   input  wire logic                                 serial_clock_in_i,
   input  wire logic                                 serial_data_in_i,
   output logic                                      clock_out_inverted_o,
   output logic                                      serial_data_out_o,
   input  wire led_cfg_pkg::gray_frame_t             gray_data_i,
   input  wire logic                                 gray_valid_i,
   output logic                                      gray_ready_o,
   output led_cfg_pkg::cfg_t                         cfg_o,
   output logic                                      cfg_written_o,
   output logic                                      packet_reject_o,
   output logic [led_cfg_pkg::NUM_CH-1:0]            channel_on_o
);
   import led_cfg_pkg::*;

   localparam int unsigned IDLE_W = $clog2(IDLE_CYCLES + 1);
   localparam int unsigned TX_W   = $clog2(2 * LINK_HALF + 1);

   if (IDLE_CYCLES < 2 || LINK_HALF < 1) begin : g_bad_param
      $error("IDLE_CYCLES must be at least 2 and LINK_HALF at least 1.");
   end

   function automatic logic parity_ok(input logic [LEN_W-1:0]  len,
                                      input logic [ADDR_W-1:0] addr,
                                      input logic [CMD_W-1:0]  cmd,
                                      input logic [PAR_W-1:0]  par);
      parity_ok = (par[0] == ^len) && (par[1] == ^addr) && (par[2] == ^cmd)
                  && (par[3] == ^par[2:0]);
   endfunction : parity_ok

   // Header bits 11:10 of the wide header are never looked at.
   function automatic logic header_ok(input logic [HDR16_W-1:0] h, input logic ten);
      if (ten) begin
         header_ok = (h[H10_CMD +: CMD_W] == CMD_CFG10)
                     && parity_ok(h[H10_LEN +: LEN_W], h[H10_ADDR +: ADDR_W],
                                  h[H10_CMD +: CMD_W], h[H10_PAR +: PAR_W]);
      end else begin
         header_ok = (h[H16_CMD_A +: CMD_W] == CMD_CFG16)
                     && (h[H16_CMD_B +: CMD_W] == h[H16_CMD_A +: CMD_W])
                     && (h[H16_LEN_A +: LEN_W] == h[H16_LEN_B +: LEN_W])
                     && parity_ok(h[H16_LEN_A +: LEN_W], h[H16_ADDR +: ADDR_W],
                                  h[H16_CMD_A +: CMD_W], h[H16_PAR +: PAR_W]);
      end
   endfunction : header_ok

   // A scrambled count spreads the on-time: the top six bits select one of 64
   // segments, and a value's low six bits decide which segments get one extra.
   function automatic logic spwm_on(input logic [GRAY_W-1:0] v, input logic [GRAY_W-1:0] c);
      logic [GRAY_W-SEG_BITS-1:0] pos;
      logic [SEG_BITS-1:0]        seg;
      pos     = c[GRAY_W-SEG_BITS-1:0];
      seg     = c[GRAY_W-1:GRAY_W-SEG_BITS];
      spwm_on = (pos < v[GRAY_W-1:SEG_BITS])
                || ((pos == v[GRAY_W-1:SEG_BITS]) && (seg < v[SEG_BITS-1:0]));
   endfunction : spwm_on

   // Link input synchronisers.
   logic [2:0] ck_sync_q;
   logic [2:0] dt_sync_q;
   logic       ck_q;
   logic       dt_q;
   logic       ck_prev_q;
   logic       bit_rise;

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         ck_sync_q <= 3'h0;
         dt_sync_q <= 3'h0;
         ck_q      <= 1'b0;
         dt_q      <= 1'b0;
         ck_prev_q <= 1'b0;
      end else begin
         ck_sync_q <= {ck_sync_q[1:0], serial_clock_in_i};
         dt_sync_q <= {dt_sync_q[1:0], serial_data_in_i};
         if (ck_sync_q[1] == ck_sync_q[2]) begin
            ck_q <= ck_sync_q[2];
         end
         if (dt_sync_q[1] == dt_sync_q[2]) begin
            dt_q <= dt_sync_q[2];
         end
         ck_prev_q <= ck_q;
      end
   end

   assign bit_rise = ck_q && !ck_prev_q;

   // Prefix detector.
   logic [IDLE_W-1:0] idle_cnt_q;
   logic              prefix_hit;

   assign prefix_hit = !ck_q && !dt_q && (idle_cnt_q == IDLE_W'(IDLE_CYCLES - 1));

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         idle_cnt_q <= '0;
      end else if (ck_q || dt_q) begin
         idle_cnt_q <= '0;
      end else if (idle_cnt_q != IDLE_W'(IDLE_CYCLES)) begin
         idle_cnt_q <= idle_cnt_q + 1'b1;
      end
   end

   // Packet receiver.
   rx_state_t           state_q;
   logic                ten_q;
   logic [HDR16_W-1:0]  hdr_q;
   logic [5:0]          hdr_cnt_q;
   logic [PAY16_W-1:0]  pay_q;
   logic [5:0]          pay_cnt_q;
   logic                line_full_q;
   logic [HDR16_W-1:0]  hdr_next;
   logic [5:0]          hdr_len;
   logic [5:0]          pay_len;
   logic                emit_req;
   logic                emit_bit;
   logic                commit;
   logic                cf1_match;
   logic [CF1_W-1:0]    new_cf1;
   logic [CF2_W-1:0]    new_cf2;
   logic                head_bad;

   assign hdr_next = {hdr_q[HDR16_W-2:0], dt_q};
   assign hdr_len  = ten_q ? 6'(HDR10_W) : 6'(HDR16_W);
   assign pay_len  = ten_q ? 6'(PAY10_W) : 6'(PAY16_W);

   always_comb begin
      if (ten_q) begin
         new_cf1   = pay_q[P10_CF1_B +: CF1_W];
         cf1_match = pay_q[P10_CF1_A +: CF1_W] == pay_q[P10_CF1_B +: CF1_W];
      end else begin
         new_cf1   = pay_q[P16_CF1_B +: CF1_W];
         cf1_match = pay_q[P16_CF1_A +: CF1_W] == pay_q[P16_CF1_B +: CF1_W];
      end
      new_cf2 = pay_q[PAY_CF2 +: CF2_W];
   end

   // own payload is the last whole one
   assign commit   = prefix_hit && (state_q == RX_PAY) && line_full_q && (pay_cnt_q == 6'h00);
   assign head_bad = bit_rise && (state_q == RX_HEAD) && (hdr_cnt_q == hdr_len - 6'h01)
                     && !header_ok(hdr_next, ten_q);

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         state_q     <= RX_WAIT;
         ten_q       <= 1'b0;
         hdr_q       <= '0;
         hdr_cnt_q   <= 6'h00;
         pay_q       <= '0;
         pay_cnt_q   <= 6'h00;
         line_full_q <= 1'b0;
      end else if (prefix_hit) begin
         state_q     <= RX_HEAD;
         hdr_cnt_q   <= 6'h00;
         pay_cnt_q   <= 6'h00;
         line_full_q <= 1'b0;
      end else if (bit_rise) begin
         case (state_q)
            RX_HEAD: begin
               hdr_q     <= hdr_next;
               hdr_cnt_q <= hdr_cnt_q + 6'h01;
               if (hdr_cnt_q == 6'(CMD_W - 1)) begin
                  if (hdr_next[CMD_W-1:0] == CMD_CFG10) begin
                     ten_q <= 1'b1;
                  end else if (hdr_next[CMD_W-1:0] == CMD_CFG16) begin
                     ten_q <= 1'b0;
                  end else begin
                     state_q <= RX_SKIP;
                  end
               end else if (hdr_cnt_q == hdr_len - 6'h01) begin
                  state_q <= head_bad ? RX_SKIP : RX_PAY;
               end
            end
            RX_PAY: begin
               pay_q <= {pay_q[PAY16_W-2:0], dt_q};
               if (pay_cnt_q == pay_len - 6'h01) begin
                  pay_cnt_q   <= 6'h00;
                  line_full_q <= 1'b1;
               end else begin
                  pay_cnt_q <= pay_cnt_q + 6'h01;
               end
            end
            RX_SKIP: begin
               state_q <= RX_SKIP;
            end
            RX_WAIT: begin
               state_q <= RX_WAIT;
            end
            default: begin
               state_q <= RX_WAIT;
            end
         endcase
      end
   end

   // payloads lag one slot, so the last one never leaves
   always_comb begin
      emit_req = 1'b0;
      emit_bit = 1'b0;
      if (bit_rise) begin
         case (state_q)
            RX_HEAD, RX_SKIP: begin
               emit_req = 1'b1;
               emit_bit = dt_q;
            end
            RX_PAY: begin
               emit_req = line_full_q;
               emit_bit = ten_q ? pay_q[PAY10_W-1] : pay_q[PAY16_W-1];
            end
            default: begin
               emit_req = 1'b0;
            end
         endcase
      end
   end

   // Downstream transmitter; a bit that arrives while one is in flight is
   // dropped, so the upstream bit period must exceed two half periods.
   logic            tx_busy_q;
   logic [TX_W-1:0] tx_cnt_q;

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         tx_busy_q            <= 1'b0;
         tx_cnt_q             <= '0;
         serial_data_out_o    <= 1'b0;
         clock_out_inverted_o <= 1'b0;
      end else if (!tx_busy_q) begin
         if (emit_req) begin
            tx_busy_q         <= 1'b1;
            tx_cnt_q          <= '0;
            serial_data_out_o <= emit_bit;
         end
      end else begin
         tx_cnt_q <= tx_cnt_q + 1'b1;
         if (tx_cnt_q == TX_W'(LINK_HALF - 1)) begin
            clock_out_inverted_o <= 1'b1;
         end
         if (tx_cnt_q == TX_W'(2 * LINK_HALF - 1)) begin
            clock_out_inverted_o <= 1'b0;
            tx_busy_q            <= 1'b0;
         end
      end
   end

   // Configuration registers.
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         cfg_o.config_word_one <= CF1_RST;
         cfg_o.config_word_two <= CF2_RST;
         cfg_written_o         <= 1'b0;
         packet_reject_o       <= 1'b0;
      end else begin
         cfg_written_o   <= 1'b0;
         packet_reject_o <= head_bad;
         if (commit && cf1_match) begin
            cfg_o.config_word_one <= new_cf1;
            cfg_o.config_word_two <= new_cf2;
            cfg_written_o         <= 1'b1;
         end else if (commit) begin
            packet_reject_o <= 1'b1;
         end
      end
   end

   // Grayscale engine.
   logic                 auto_sync;
   logic                 ten_mode;
   logic [1:0]           div_sel;
   logic [2:0]           div_cnt_q;
   logic                 tick;
   logic [GRAY_W-1:0]    gs_cnt_q;
   logic                 cycle_end;
   logic                 buf_valid;
   logic                 buf_ready;
   gray_frame_t          buf_data;
   gray_frame_t          active_q;
   logic                 load;
   logic                 restart;

   assign auto_sync = cfg_o.config_word_one[CF1_AUTO_SYNC];
   assign ten_mode  = cfg_o.config_word_one[CF1_MODE10];
   assign div_sel   = cfg_o.config_word_one[CF1_DIV_LSB +: 2];

   // divider of one, two, four or eight
   assign tick = div_cnt_q == 3'((4'h1 << div_sel) - 4'h1);

   always_ff @(posedge sys_clk_i) begin
      if (rst_i || tick) begin
         div_cnt_q <= 3'h0;
      end else begin
         div_cnt_q <= div_cnt_q + 3'h1;
      end
   end

   assign cycle_end = tick && (ten_mode ? (gs_cnt_q[GRAY10_W-1:0] == '1) : (gs_cnt_q == '1));

   // auto sync waits for the cycle end; manual takes data at once
   assign buf_ready = auto_sync ? cycle_end : 1'b1;
   assign load      = buf_valid && buf_ready;
   assign restart   = (cfg_written_o && cfg_o.config_word_one[CF1_CNT_RST])
                      || (load && !auto_sync);

   led_frame_buffer #(
      .WIDTH ($bits(gray_frame_t)),
      .DEPTH (2)
   ) u_frame_buffer (
      .sys_clk_i   (sys_clk_i),
      .rst_i       (rst_i),
      .in_data_i   (gray_data_i),
      .in_valid_i  (gray_valid_i),
      .in_ready_o  (gray_ready_o),
      .out_data_o  (buf_data),
      .out_valid_o (buf_valid),
      .out_ready_i (buf_ready)
   );

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         gs_cnt_q <= '0;
      end else if (restart) begin
         gs_cnt_q <= '0;
      end else if (tick) begin
         // narrow cycle wraps after 1024 counts
         if (ten_mode && gs_cnt_q[GRAY10_W-1:0] == '1) begin
            gs_cnt_q <= '0;
         end else begin
            gs_cnt_q <= gs_cnt_q + 1'b1;
         end
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         active_q <= '0;
      end else if (load) begin
         active_q <= buf_data;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         channel_on_o <= '0;
      end else begin
         for (int ch = 0; ch < NUM_CH; ch++) begin
            if (ten_mode) begin
               channel_on_o[ch] <= gs_cnt_q[GRAY10_W-1:0] < active_q[ch][GRAY10_W-1:0];
            end else begin
               channel_on_o[ch] <= spwm_on(active_q[ch], gs_cnt_q);
            end
         end
      end
   end
endmodule : led_driver_config_packet_pwm
`default_nettype wire

// ---- led_cfg_pkg.sv ----
`default_nettype none
package led_cfg_pkg;
   // Clock and link timing.
   localparam int unsigned CLK_PERIOD_NS        = 25;
   localparam int unsigned IDLE_MIN_LINK_CYCLES = 172;
   // Slowest link bit period that the prefix detector is sized for.
   localparam int unsigned LINK_BIT_NS  = 1000;
   localparam int unsigned LINK_BIT_CYC = (LINK_BIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned IDLE_CYC     = (IDLE_MIN_LINK_CYCLES + 1) * LINK_BIT_CYC;
   // Least half period of the regenerated downstream clock.
   localparam int unsigned LINK_HALF_NS  = 100;
   localparam int unsigned LINK_HALF_RAW = (LINK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned LINK_HALF_CYC = (LINK_HALF_RAW < 1) ? 1 : LINK_HALF_RAW;

   // Packet formats.
   localparam int unsigned CMD_W     = 6;
   localparam logic [5:0]  CMD_CFG16 = 6'h23;
   localparam logic [5:0]  CMD_CFG10 = 6'h37;
   localparam int unsigned LEN_W     = 10;
   localparam int unsigned ADDR_W    = 10;
   localparam int unsigned PAR_W     = 4;
   localparam int unsigned HDR16_W   = 48;
   localparam int unsigned HDR10_W   = 30;
   localparam int unsigned PAY16_W   = 48;
   localparam int unsigned PAY10_W   = 30;
   localparam int unsigned H16_CMD_A = 42;
   localparam int unsigned H16_ADDR  = 32;
   localparam int unsigned H16_CMD_B = 26;
   localparam int unsigned H16_LEN_A = 16;
   localparam int unsigned H16_PAR   = 12;
   localparam int unsigned H16_LEN_B = 0;
   localparam int unsigned H10_CMD   = 24;
   localparam int unsigned H10_PAR   = 20;
   localparam int unsigned H10_ADDR  = 10;
   localparam int unsigned H10_LEN   = 0;
   localparam int unsigned P16_CF1_A = 32;
   localparam int unsigned P16_CF1_B = 16;
   localparam int unsigned P10_CF1_A = 20;
   localparam int unsigned P10_CF1_B = 10;
   localparam int unsigned PAY_CF2   = 0;

   // Configuration words.
   localparam int unsigned CF1_W         = 10;
   localparam int unsigned CF2_W         = 3;
   localparam logic [9:0]  CF1_RST       = 10'h11e;
   localparam logic [2:0]  CF2_RST       = 3'h7;
   localparam int unsigned CF1_AUTO_SYNC = 3;
   localparam int unsigned CF1_CNT_RST   = 4;
   localparam int unsigned CF1_MODE10    = 7;
   localparam int unsigned CF1_DIV_LSB   = 8;

   // Grayscale engine.
   localparam int unsigned NUM_CH   = 12;
   localparam int unsigned GRAY_W   = 16;
   localparam int unsigned GRAY10_W = 10;
   localparam int unsigned SEG_BITS = 6;

   typedef struct packed {
      logic [CF1_W-1:0] config_word_one;
      logic [CF2_W-1:0] config_word_two;
   } cfg_t;

   typedef logic [NUM_CH-1:0][GRAY_W-1:0] gray_frame_t;

   typedef enum logic [1:0] {
      RX_WAIT = 2'b00,
      RX_HEAD = 2'b01,
      RX_PAY  = 2'b10,
      RX_SKIP = 2'b11
   } rx_state_t;
endpackage : led_cfg_pkg
`default_nettype wire

// ---- led_frame_buffer.sv ----
`default_nettype none
module led_frame_buffer #(
   parameter int unsigned WIDTH = 16,
   parameter int unsigned DEPTH = 2
) (
   input  wire logic             sys_clk_i,
   input  wire logic             rst_i,
   input  wire logic [WIDTH-1:0] in_data_i,
   input  wire logic             in_valid_i,
   output logic                  in_ready_o,
   output logic [WIDTH-1:0]      out_data_o,
   output logic                  out_valid_o,
   input  wire logic             out_ready_i
);
   localparam int unsigned PTR_W = (DEPTH < 2) ? 1 : $clog2(DEPTH);
   localparam int unsigned CNT_W = $clog2(DEPTH + 1);

   if (DEPTH < 2) begin : g_bad_depth
      $error("led_frame_buffer needs at least two entries.");
   end

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [PTR_W-1:0] wr_ptr_q;
   logic [PTR_W-1:0] rd_ptr_q;
   logic [CNT_W-1:0] count_q;
   logic             push;
   logic             pop;

   assign push        = in_valid_i && in_ready_o;
   assign pop         = out_valid_o && out_ready_i;
   assign out_valid_o = (count_q != '0);
   assign out_data_o  = mem_q[rd_ptr_q];

   function automatic logic [PTR_W-1:0] next_ptr(input logic [PTR_W-1:0] p);
      next_ptr = (p == PTR_W'(DEPTH - 1)) ? '0 : p + 1'b1;
   endfunction : next_ptr

   always_ff @(posedge sys_clk_i) begin
      if (push) begin
         mem_q[wr_ptr_q] <= in_data_i;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         wr_ptr_q   <= '0;
         rd_ptr_q   <= '0;
         count_q    <= '0;
         in_ready_o <= 1'b0;
      end else begin
         if (push) begin
            wr_ptr_q <= next_ptr(wr_ptr_q);
         end
         if (pop) begin
            rd_ptr_q <= next_ptr(rd_ptr_q);
         end
         // Ready is registered, so it is computed from the next count.
         if (push && !pop) begin
            count_q    <= count_q + 1'b1;
            in_ready_o <= (count_q + 1'b1) != CNT_W'(DEPTH);
         end else if (pop && !push) begin
            count_q    <= count_q - 1'b1;
            in_ready_o <= 1'b1;
         end else begin
            in_ready_o <= count_q != CNT_W'(DEPTH);
         end
      end
   end
endmodule : led_frame_buffer
`default_nettype wire

// ---- led_link_src.sv ----
`default_nettype none
module led_link_src #(
   parameter int IDLE_HOLD = 60
) (
   input  wire logic sys_clk_i,
   output var logic  link_clk_o,
   output var logic  link_dat_o
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      link_clk_o = 1'b0;
      link_dat_o = 1'b0;
   end
   // Six-cycle phases stay clear of the input filter and the re-send rate.
   task automatic send_bit(input logic b);
      @(posedge sys_clk_i) #2 link_dat_o = b;
      repeat (6) @(posedge sys_clk_i);
      #2 link_clk_o = 1'b1;
      repeat (6) @(posedge sys_clk_i);
      #2 link_clk_o = 1'b0;
   endtask : send_bit
   task automatic prefix();
      @(posedge sys_clk_i) #2 link_dat_o = 1'b0;
      repeat (IDLE_HOLD) @(posedge sys_clk_i);
   endtask : prefix
   task automatic send48(input logic [47:0] v);
      for (int i = 47; i >= 0; i--) send_bit(v[i]);
   endtask : send48
   task automatic send30(input logic [29:0] v);
      for (int i = 29; i >= 0; i--) send_bit(v[i]);
   endtask : send30
endmodule : led_link_src
`default_nettype wire

// ---- led_driver_chk.sv ----
`default_nettype none
module led_driver_chk #(
   parameter int LINK_HALF = 1
) (
   input wire logic              sys_clk_i,
   input wire logic              rst_i,
   input wire logic              serial_clock_in_i,
   input wire logic              serial_data_in_i,
   input wire logic              clock_out_inverted_o,
   input wire logic              serial_data_out_o,
   input wire logic              gray_valid_i,
   input wire logic              gray_ready_o,
   input wire led_cfg_pkg::cfg_t cfg_o,
   input wire logic              cfg_written_o,
   input wire logic              packet_reject_o
);
   timeunit 1ns;
   timeprecision 100ps;
   import led_cfg_pkg::*;
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (rst_i);
   wr_pulse_a:
      assert property (cfg_written_o |=> !cfg_written_o) else $error("write pulse too long");
   rej_pulse_a:
      assert property (packet_reject_o |=> !packet_reject_o) else $error("reject too long");
   wr_rej_excl_a:
      assert property (!(cfg_written_o && packet_reject_o)) else $error("write and reject");
   cfg_hold_a:
      assert property ($changed(cfg_o) |-> cfg_written_o) else $error("cfg changed unwritten");
   wr_idle_a:
      assert property (cfg_written_o |-> !serial_clock_in_i && !serial_data_in_i
         && !$past(serial_clock_in_i, 8)) else $error("write without idle link");
   ck_high_a:
      assert property ($rose(clock_out_inverted_o) |-> ##LINK_HALF $fell(clock_out_inverted_o))
         else $error("downstream clock width");
   dout_setup_a:
      assert property ($rose(clock_out_inverted_o) |-> $stable(serial_data_out_o))
         else $error("downstream data moved at clock");
   buf_room_a:
      assert property (gray_ready_o && !gray_valid_i |=> gray_ready_o) else $error("room lost");
endmodule : led_driver_chk
bind led_driver_config_packet_pwm led_driver_chk #(.LINK_HALF(LINK_HALF)) i_led_driver_chk (
   .sys_clk_i, .rst_i, .serial_clock_in_i, .serial_data_in_i, .clock_out_inverted_o,
   .serial_data_out_o, .gray_valid_i, .gray_ready_o, .cfg_o, .cfg_written_o, .packet_reject_o);
`default_nettype wire

// ---- testbench.sv ----
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   import led_cfg_pkg::*;
   logic              sys_clk_i = 1'b0;
   logic              rst_i = 1'b1;
   logic              gray_valid_i = 1'b0;
   gray_frame_t       gray_data_i = '0;
   logic              sck, sdat, ck_out, d_out, gray_ready_o, cfg_written_o, packet_reject_o;
   cfg_t              cfg_o;
   logic [NUM_CH-1:0] channel_on_o;
   logic [47:0]       fwd_q = '0;
   int                fwd_n = 0, n_wr = 0, n_rj = 0, errors = 0, total_checks = 0;
   always #12.5 sys_clk_i = ~sys_clk_i;
   led_driver_config_packet_pwm #(.IDLE_CYCLES(40), .LINK_HALF(1)) i_led_driver_config_packet_pwm (
      .sys_clk_i, .rst_i, .serial_clock_in_i(sck), .serial_data_in_i(sdat),
      .clock_out_inverted_o(ck_out), .serial_data_out_o(d_out), .gray_data_i, .gray_valid_i,
      .gray_ready_o, .cfg_o, .cfg_written_o, .packet_reject_o, .channel_on_o);
   led_link_src i_led_link_src (.sys_clk_i, .link_clk_o(sck), .link_dat_o(sdat));
   always @(posedge ck_out) begin
      fwd_q <= {fwd_q[46:0], d_out};
      fwd_n <= fwd_n + 1;
   end
   always @(posedge sys_clk_i) begin
      if (cfg_written_o === 1'b1) n_wr <= n_wr + 1;
      if (packet_reject_o === 1'b1) n_rj <= n_rj + 1;
   end
   task automatic chk(input string what, input logic [47:0] exp, input logic [47:0] got);
      total_checks++;
      if (got !== exp) begin
         errors++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   function automatic logic [3:0] par(input logic [5:0] c, input logic [9:0] l);
      logic [2:0] p;
      p = {^c, 1'b0, ^l};
      return {^p, p};
   endfunction : par
   // Spare bits set to prove they are ignored.
   function automatic logic [47:0] hdr16(input logic [5:0] c2, input logic [9:0] l, l2);
      return {CMD_CFG16, 10'h0, c2, l, par(CMD_CFG16, l), 2'b11, l2};
   endfunction : hdr16
   function automatic logic [47:0] pay16(input logic [9:0] a, b, input logic [2:0] w2);
      return {6'h0, a, 6'h0, b, 13'h0, w2};
   endfunction : pay16
   function automatic logic [29:0] hdr10(input logic [9:0] l, input logic [3:0] flip);
      return {CMD_CFG10, par(CMD_CFG10, l) ^ flip, 10'h0, l};
   endfunction : hdr10
   function automatic logic [29:0] pay10(input logic [9:0] a, b, input logic [2:0] w2);
      return {a, b, 7'h0, w2};
   endfunction : pay10
   task automatic send_rej(input logic wide, input logic [47:0] h, p);
      int   r0, w0;
      cfg_t c0;
      r0 = n_rj;
      w0 = n_wr;
      c0 = cfg_o;
      i_led_link_src.prefix();
      if (wide) begin
         i_led_link_src.send48(h);
         i_led_link_src.send48(p);
      end else begin
         i_led_link_src.send30(h[29:0]);
         i_led_link_src.send30(p[29:0]);
      end
      i_led_link_src.prefix();
      chk("reject pulses", 1, 48'(n_rj - r0));
      chk("write pulses", 0, 48'(n_wr - w0));
      chk("cfg unchanged", 48'(c0), 48'(cfg_o));
   endtask : send_rej
   task automatic t_reset();
      chk("cfg after reset", 48'({CF1_RST, CF2_RST}), 48'(cfg_o));
      chk("ready after reset", 1, 48'(gray_ready_o));
   endtask : t_reset
   // Automatic sync holds frames for a whole wide cycle, so the buffer must fill.
   task automatic t_buffer();
      @(posedge sys_clk_i) #2 gray_valid_i = 1'b1;
      repeat (6) @(posedge sys_clk_i);
      #2 chk("ready when full", 0, 48'(gray_ready_o));
      gray_valid_i = 1'b0;
   endtask : t_buffer
   task automatic t_wide_ok();
      logic [47:0] a, b;
      int          w0, f0;
      a = pay16(10'h2d5, 10'h2d5, 3'h2);
      b = pay16(10'h01e, 10'h01e, 3'h5);
      w0 = n_wr;
      f0 = fwd_n;
      i_led_link_src.prefix();
      i_led_link_src.send48(hdr16(CMD_CFG16, 10'd1, 10'd1));
      i_led_link_src.send48(a);
      i_led_link_src.send48(b);
      i_led_link_src.prefix();
      chk("write pulses", 1, 48'(n_wr - w0));
      chk("cfg kept", 48'({10'h01e, 3'h5}), 48'(cfg_o));
      chk("forwarded bits", 96, 48'(fwd_n - f0));
      chk("forwarded payload", a, fwd_q);
   endtask : t_wide_ok
   task automatic t_rejects();
      send_rej(1'b1, hdr16(CMD_CFG16, 10'd0, 10'd0), pay16(10'h3c1, 10'h3c0, 3'h1));
      send_rej(1'b1, hdr16(CMD_CFG16, 10'd0, 10'd2), pay16(10'h3c1, 10'h3c1, 3'h1));
      send_rej(1'b1, hdr16(CMD_CFG10, 10'd0, 10'd0), pay16(10'h3c1, 10'h3c1, 3'h1));
      for (int i = 0; i < 4; i++)
         send_rej(1'b0, 48'(hdr10(10'd0, 4'(1 << i))), 48'(pay10(10'h3c1, 10'h3c1, 3'h1)));
   endtask : t_rejects
   task automatic t_narrow_ok();
      int w0, f0;
      w0 = n_wr;
      f0 = fwd_n;
      i_led_link_src.prefix();
      i_led_link_src.send30(hdr10(10'd0, 4'h0));
      i_led_link_src.send30(pay10(10'h196, 10'h196, 3'h6));
      i_led_link_src.prefix();
      chk("write pulses", 1, 48'(n_wr - w0));
      chk("cfg narrow", 48'({10'h196, 3'h6}), 48'(cfg_o));
      chk("forwarded bits", 30, 48'(fwd_n - f0));
      chk("buffer drained", 1, 48'(gray_ready_o));
   endtask : t_narrow_ok
   task automatic t_pwm(input int exp [4]);
      int          on [4];
      logic [15:0] v [4];
      v = '{16'd5, 16'hfc00, 16'd1023, 16'd512};
      on = '{0, 0, 0, 0};
      for (int c = 0; c < 4; c++) gray_data_i[c] = v[c];
      @(posedge sys_clk_i) #2 gray_valid_i = 1'b1;
      while (gray_ready_o !== 1'b1) @(posedge sys_clk_i) #2;
      @(posedge sys_clk_i) #2 gray_valid_i = 1'b0;
      repeat (10) @(posedge sys_clk_i);
      repeat (2048) begin
         @(posedge sys_clk_i);
         for (int c = 0; c < 4; c++) if (channel_on_o[c] === 1'b1) on[c]++;
      end
      for (int c = 0; c < 4; c++) chk("on cycles", 48'(exp[c]), 48'(on[c]));
   endtask : t_pwm
   // Wide mode, divide by one, manual sync: the window is two segments long, early in the cycle.
   task automatic t_wide_pwm();
      i_led_link_src.prefix();
      i_led_link_src.send48(hdr16(CMD_CFG16, 10'd0, 10'd0));
      i_led_link_src.send48(pay16(10'h016, 10'h016, 3'h7));
      i_led_link_src.prefix();
      t_pwm('{2, 2016, 32, 16});
   endtask : t_wide_pwm
   task automatic print_verdict();
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : print_verdict
   initial begin
      repeat (5) @(posedge sys_clk_i);
      #2 rst_i = 1'b0;
      @(posedge sys_clk_i) #2;
      t_reset();
      t_buffer();
      t_wide_ok();
      t_rejects();
      t_narrow_ok();
      t_pwm('{10, 0, 2046, 1024});
      t_wide_pwm();
      print_verdict();
   end
   initial begin
      #1000000;
      errors++;
      print_verdict();
   end
endmodule : testbench
`default_nettype wire
